// ===== logic/double_precision_float_add.sv
// double-precision float add sequencer, datapath and AHB-Lite register slave
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module double_precision_float_add
    import dfadd_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output mem_req_s         mem_req,
    input  wire mem_rsp_s    mem_rsp,
    output logic             overlap_inhibit,
    output logic             busy
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [26:0] frac(input logic [35:0] w);
        frac = w[FRAC_MSB:0];
    endfunction

    function automatic logic [7:0] chr(input logic [35:0] w);
        chr = w[CHAR_HI:CHAR_LO];
    endfunction

    function automatic logic [35:0] pack(input logic s, input logic [7:0] c,
                                         input logic [26:0] f);
        pack = {s, c, f};
    endfunction

    function automatic logic [27:0] add27(input logic [26:0] a,
                                          input logic [26:0] b,
                                          input logic cin);
        add27 = {1'b0, a} + {1'b0, b} + {27'h0, cin};
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    seq_state_e          state_ff;
    logic [1:0]          step_ff;
    logic                raw_ff;
    logic [MEM_AW-1:0]   addr_ff;
    logic [35:0]         high_ff;
    logic [35:0]         low_ff;
    logic [35:0]         mop_ff;
    logic [35:0]         bop_ff;
    logic [35:0]         scr_ff;
    logic signed [9:0]   exp_ff;
    logic [7:0]          diff_ff;
    logic                unlike_ff;
    logic                c9_ff;
    logic                carry_ff;
    logic                sign_ff;
    logic                done_ff;
    logic                ovf_ff;
    logic                unf_ff;
    mem_req_s            mem_req_ff;
    logic                ap_wr_ff;
    logic [7:0]          ap_addr_ff;
    logic [31:0]         hrdata_ff;

    logic                ap_take;
    logic                wr_ctrl;
    logic                start;
    logic                idle;
    logic                addr_big;
    logic [7:0]          big_chr;
    logic [7:0]          sml_chr;
    logic [27:0]         sum1;
    logic [27:0]         sum2;
    logic [27:0]         neg_low;
    logic [27:0]         neg_high;
    logic                res_zero;
    logic signed [9:0]   low_exp;

    assign idle     = (state_ff == S_IDLE);
    assign ap_take  = hsel && hready && htrans[1];
    assign wr_ctrl  = ap_wr_ff && (ap_addr_ff == CTRL_OFF);
    assign start    = wr_ctrl && hwdata[CTRL_START] && idle;

    assign addr_big = (chr(mop_ff) >= chr(high_ff));
    assign big_chr  = addr_big ? chr(mop_ff) : chr(high_ff);
    assign sml_chr  = addr_big ? chr(high_ff) : chr(mop_ff);

    // first add: operand low fraction with smaller low fraction
    assign sum1     = add27(frac(mop_ff),
                            unlike_ff ? ~frac(high_ff) : frac(high_ff),
                            unlike_ff);
    // second add: high fractions plus carry kept from the first add
    assign sum2     = add27(frac(mop_ff),
                            unlike_ff ? ~frac(high_ff) : frac(high_ff),
                            c9_ff);
    assign neg_low  = add27(~frac(mop_ff), 27'h0, 1'b1);
    assign neg_high = add27(~frac(high_ff), 27'h0, carry_ff);
    assign res_zero = (frac(high_ff) == 27'h0) && (frac(low_ff) == 27'h0);
    assign low_exp  = exp_ff - $signed({2'b00, LOW_CHAR_GAP});

    // ------------------------------------------------------------------
    // sequencer and datapath
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff   <= S_IDLE;
            step_ff    <= 2'b00;
            raw_ff     <= 1'b0;
            addr_ff    <= '0;
            high_ff    <= WORD_RST;
            low_ff     <= WORD_RST;
            mop_ff     <= WORD_RST;
            bop_ff     <= WORD_RST;
            scr_ff     <= WORD_RST;
            exp_ff     <= EXP_RST;
            diff_ff    <= 8'h00;
            unlike_ff  <= 1'b0;
            c9_ff      <= 1'b0;
            carry_ff   <= 1'b0;
            sign_ff    <= 1'b0;
            done_ff    <= 1'b0;
            ovf_ff     <= 1'b0;
            unf_ff     <= 1'b0;
            mem_req_ff <= '0;
        end else begin
            case (state_ff)
            S_IDLE: begin
                if (ap_wr_ff && ap_addr_ff == HIGH_LO_OFF)
                    high_ff[31:0] <= hwdata;
                if (ap_wr_ff && ap_addr_ff == HIGH_HI_OFF)
                    high_ff[35:32] <= hwdata[3:0];
                if (ap_wr_ff && ap_addr_ff == LOW_LO_OFF)
                    low_ff[31:0] <= hwdata;
                if (ap_wr_ff && ap_addr_ff == LOW_HI_OFF)
                    low_ff[35:32] <= hwdata[3:0];
                if (start) begin
                    raw_ff     <= hwdata[CTRL_RAW];
                    addr_ff    <= hwdata[CTRL_ADDR_LO +: MEM_AW];
                    done_ff    <= 1'b0;
                    ovf_ff     <= 1'b0;
                    unf_ff     <= 1'b0;
                    step_ff    <= 2'b00;
                    mem_req_ff <= '{valid: 1'b1,
                                    addr: hwdata[CTRL_ADDR_LO +: MEM_AW]};
                    state_ff   <= S_FETCH_Y;
                end
            end
            S_FETCH_Y: begin
                if (mem_rsp.ack) begin
                    mop_ff          <= mem_rsp.data;
                    mem_req_ff.addr <= addr_ff + 15'h0001;
                    state_ff        <= S_FETCH_N;
                end
            end
            S_FETCH_N: begin
                if (mem_rsp.ack) begin
                    bop_ff     <= mem_rsp.data;
                    mem_req_ff <= '0;
                    state_ff   <= S_STEP0;
                end
            end
            S_STEP0: begin
                unlike_ff <= high_ff[SIGN_POS] ^ mop_ff[SIGN_POS];
                exp_ff    <= $signed({2'b00, big_chr});
                diff_ff   <= big_chr - sml_chr;
                sign_ff   <= addr_big ? mop_ff[SIGN_POS]
                                      : high_ff[SIGN_POS];
                if (addr_big) begin
                    scr_ff  <= mop_ff;
                    // second word: own sign and characteristic ignored
                    mop_ff  <= pack(mop_ff[SIGN_POS],
                                    chr(mop_ff) - LOW_CHAR_GAP,
                                    frac(bop_ff));
                    high_ff <= pack(high_ff[SIGN_POS],
                                    chr(high_ff) - LOW_CHAR_GAP,
                                    frac(low_ff));
                    low_ff  <= high_ff;
                end else begin
                    scr_ff  <= high_ff;
                    mop_ff  <= pack(high_ff[SIGN_POS],
                                    chr(high_ff) - LOW_CHAR_GAP,
                                    frac(low_ff));
                    high_ff <= pack(mop_ff[SIGN_POS],
                                    chr(mop_ff) - LOW_CHAR_GAP,
                                    frac(bop_ff));
                    low_ff  <= mop_ff;
                end
                if ((big_chr - sml_chr) > FAR_DIFF_MAX &&
                    (addr_big ? mop_ff[FRAC_MSB]
                              : high_ff[FRAC_MSB])) begin
                    high_ff  <= addr_big ? mop_ff : high_ff;
                    low_ff   <= addr_big ? bop_ff : low_ff;
                    state_ff <= S_FACT5;
                end else begin
                    step_ff  <= 2'b01;
                    state_ff <= S_FACT1;
                end
            end
            S_FACT1: begin
                if (diff_ff != 8'h00) begin
                    // low bit of the low part feeds the high part only
                    high_ff[FRAC_MSB:0] <= {low_ff[0],
                                            high_ff[FRAC_MSB:1]};
                    low_ff[FRAC_MSB:0]  <= {1'b0,
                                            low_ff[FRAC_MSB:1]};
                    diff_ff <= diff_ff - 8'h01;
                end else begin
                    state_ff <= S_FACT2;
                end
            end
            S_FACT2: begin
                c9_ff               <= sum1[27];
                high_ff[FRAC_MSB:0] <= frac(low_ff);
                mop_ff[FRAC_MSB:0]  <= sum1[26:0];
                step_ff             <= 2'b10;
                state_ff            <= S_STEP2;
            end
            S_STEP2: begin
                scr_ff[FRAC_MSB:0] <= frac(mop_ff);
                mop_ff[FRAC_MSB:0] <= frac(scr_ff);
                step_ff            <= 2'b11;
                state_ff           <= S_ADD2;
            end
            S_ADD2: begin
                if (!unlike_ff) begin
                    if (sum2[27]) begin
                        high_ff[FRAC_MSB:0] <= {1'b1, sum2[26:1]};
                        low_ff[FRAC_MSB:0]  <= {sum2[0],
                                                scr_ff[FRAC_MSB:1]};
                        exp_ff <= exp_ff + 10'sd1;
                    end else begin
                        high_ff[FRAC_MSB:0] <= sum2[26:0];
                        low_ff[FRAC_MSB:0]  <= frac(scr_ff);
                    end
                    state_ff <= raw_ff ? S_FACT5 : S_FACT4;
                end else if (sum2[27]) begin
                    high_ff[FRAC_MSB:0] <= sum2[26:0];
                    low_ff[FRAC_MSB:0]  <= frac(scr_ff);
                    state_ff <= raw_ff ? S_FACT5 : S_FACT4;
                end else begin
                    high_ff[FRAC_MSB:0] <= sum2[26:0];
                    mop_ff[FRAC_MSB:0]  <= frac(scr_ff);
                    state_ff            <= S_FACT6;
                end
            end
            S_FACT6: begin
                mop_ff[FRAC_MSB:0] <= neg_low[26:0];
                carry_ff           <= neg_low[27];
                state_ff           <= S_FACT7;
            end
            S_FACT7: begin
                low_ff[FRAC_MSB:0]  <= frac(mop_ff);
                high_ff[FRAC_MSB:0] <= neg_high[26:0];
                sign_ff             <= ~sign_ff;
                state_ff <= raw_ff ? S_FACT5 : S_FACT4;
            end
            S_FACT4: begin
                // normalization shared with single precision
                if (res_zero || high_ff[FRAC_MSB]) begin
                    state_ff <= S_FACT5;
                end else begin
                    high_ff[FRAC_MSB:0] <= {high_ff[FRAC_MSB-1:0],
                                            low_ff[FRAC_MSB]};
                    low_ff[FRAC_MSB:0]  <= {low_ff[FRAC_MSB-1:0],
                                            1'b0};
                    exp_ff <= exp_ff - 10'sd1;
                end
            end
            S_FACT5: begin
                if (res_zero && !raw_ff) begin
                    high_ff <= pack(sign_ff, 8'h00, 27'h0);
                    low_ff  <= pack(sign_ff, 8'h00, 27'h0);
                end else begin
                    high_ff <= pack(sign_ff, exp_ff[7:0],
                                    frac(high_ff));
                    low_ff  <= pack(sign_ff, low_exp[7:0],
                                    frac(low_ff));
                    ovf_ff  <= (exp_ff > $signed(EXP_MAX));
                    unf_ff  <= (exp_ff < 10'sd0);
                end
                done_ff  <= 1'b1;
                step_ff  <= 2'b00;
                state_ff <= S_IDLE;
            end
            default: begin
                state_ff <= S_IDLE;
            end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] st;
        st = 32'h0;
        st[ST_BUSY]                 = !idle;
        st[ST_DONE]                 = done_ff;
        st[ST_OVF]                  = ovf_ff;
        st[ST_UNF]                  = unf_ff;
        st[ST_STEP_LO +: 2]         = step_ff;
        st[ST_STATE_LO +: 4]        = state_ff;
        case (a)
        CTRL_OFF:    reg_read = {1'b0, addr_ff, 14'h0, raw_ff, 1'b0};
        STATUS_OFF:  reg_read = st;
        HIGH_LO_OFF: reg_read = high_ff[31:0];
        HIGH_HI_OFF: reg_read = {28'h0, high_ff[35:32]};
        LOW_LO_OFF:  reg_read = low_ff[31:0];
        LOW_HI_OFF:  reg_read = {28'h0, low_ff[35:32]};
        MOP_LO_OFF:  reg_read = mop_ff[31:0];
        MOP_HI_OFF:  reg_read = {28'h0, mop_ff[35:32]};
        BOP_LO_OFF:  reg_read = bop_ff[31:0];
        BOP_HI_OFF:  reg_read = {28'h0, bop_ff[35:32]};
        SCR_LO_OFF:  reg_read = scr_ff[31:0];
        SCR_HI_OFF:  reg_read = {28'h0, scr_ff[35:32]};
        default:     reg_read = 32'h0;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff   <= 1'b0;
            ap_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h0;
        end else begin
            ap_wr_ff <= ap_take && hwrite;
            if (ap_take) begin
                ap_addr_ff <= haddr[7:0];
                if (!hwrite)
                    hrdata_ff <= (haddr[31:8] == 24'h0)
                                 ? reg_read(haddr[7:0]) : 32'h0;
            end
        end
    end

    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = hrdata_ff;
    assign mem_req         = mem_req_ff;
    assign busy            = !idle;
    assign overlap_inhibit = !idle;

endmodule

`default_nettype wire

// ===== shared/dfadd_pkg.sv
// constants, types and states for the double-precision float add block
// ----------------------------------------------------------------------
// Operation
// - result high fraction in result-high, low in result-low, low char 27 below
// - addressed operand: word Y to memory-operand, word Y+1 to backup-operand
// - second word: fraction only; sign from first, characteristic first minus 27
// - implied operand: result-low sign and characteristic derived from result-high
// - binary point left of bit 9; fraction occupies bits 9-35
// - scratch register overwritten as temporary storage every instruction
// - overlap inhibited during E and L cycles while backup register busy
// - step 0 puts larger operand in scratch/memory-operand, smaller in results
// - end of first L0 sets trigger 1 and advances sequencer to step 1
// - difference over octal 77 with normalized larger operand ends early
// - pre-normalize shifts result-low bit 35 into result-high bit 9 only
// - first add uses two's complement when signs differ
// - first add copies result-low fraction, then exchanges result-high and operand
// - step 2 exchanges scratch and operand fractions, sets trigger 2
// - step 3 adds step-2 bit-9 carry into bit 35 of second add
// - true second add goes to trigger 4, or 5 when no normalization
// - complement add with carry is true form, zero-checked, trigger 4
// - complement add without carry: trigger 6 negates operand, sets 7 and 3
// - trigger 7 moves operand to result-low, complements result-high with carry
// - sequencer modifies triggers 1-7 except trigger 4
// - normalized add: larger operand sign, always normalized, bounded L cycles
// - raw add skips normalization, result may be unnormal
// ----------------------------------------------------------------------
package dfadd_pkg;

    // word layout: bit index = 35 - documented bit number
    localparam int WORD_W    = 36;
    localparam int FRAC_W    = 27;
    localparam int SIGN_POS  = 35;
    localparam int CHAR_HI   = 34;
    localparam int CHAR_LO   = 27;
    localparam int FRAC_MSB  = 26;
    localparam int MEM_AW    = 15;

    localparam logic [7:0]  LOW_CHAR_GAP  = 8'h1B;
    localparam logic [7:0]  FAR_DIFF_MAX  = 8'h3F;
    localparam logic [35:0] WORD_RST      = 36'h0;
    localparam logic [9:0]  EXP_RST       = 10'h000;
    localparam logic [9:0]  EXP_MAX       = 10'h0FF;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] STATUS_OFF  = 8'h04;
    localparam logic [7:0] HIGH_LO_OFF = 8'h08;
    localparam logic [7:0] HIGH_HI_OFF = 8'h0C;
    localparam logic [7:0] LOW_LO_OFF  = 8'h10;
    localparam logic [7:0] LOW_HI_OFF  = 8'h14;
    localparam logic [7:0] MOP_LO_OFF  = 8'h18;
    localparam logic [7:0] MOP_HI_OFF  = 8'h1C;
    localparam logic [7:0] BOP_LO_OFF  = 8'h20;
    localparam logic [7:0] BOP_HI_OFF  = 8'h24;
    localparam logic [7:0] SCR_LO_OFF  = 8'h28;
    localparam logic [7:0] SCR_HI_OFF  = 8'h2C;

    // control and status fields
    localparam int CTRL_START   = 0;
    localparam int CTRL_RAW     = 1;
    localparam int CTRL_ADDR_LO = 16;
    localparam int ST_BUSY      = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_OVF       = 2;
    localparam int ST_UNF       = 3;
    localparam int ST_STEP_LO   = 4;
    localparam int ST_STATE_LO  = 8;

    typedef enum logic [3:0] {
        S_IDLE    = 4'b0000,
        S_FETCH_Y = 4'b0001,
        S_FETCH_N = 4'b0010,
        S_STEP0   = 4'b0011,
        S_FACT1   = 4'b0100,
        S_FACT2   = 4'b0101,
        S_STEP2   = 4'b0110,
        S_ADD2    = 4'b0111,
        S_FACT6   = 4'b1000,
        S_FACT7   = 4'b1001,
        S_FACT4   = 4'b1010,
        S_FACT5   = 4'b1011
    } seq_state_e;

    typedef struct packed {
        logic              valid;
        logic [MEM_AW-1:0] addr;
    } mem_req_s;

    typedef struct packed {
        logic              ack;
        logic [WORD_W-1:0] data;
    } mem_rsp_s;

endpackage

// ===== dv/mem_model.sv
// memory partner answering the two-word operand fetch
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import dfadd_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    input  wire mem_req_s mem_req,
    output mem_rsp_s      mem_rsp
);
    logic [WORD_W-1:0] words [0:15];
    logic [1:0]        wait_ff;
    // one ack pulse per word, the second after a random wait; idle data keeps toggling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_rsp <= '0;
            wait_ff <= 2'h0;
        end else if (mem_req.valid && !mem_rsp.ack && wait_ff == 2'h0) begin
            mem_rsp.ack  <= 1'b1;
            mem_rsp.data <= words[mem_req.addr[3:0]];
            wait_ff      <= 2'($urandom_range(3));
        end else begin
            mem_rsp.ack  <= 1'b0;
            mem_rsp.data <= ~mem_rsp.data;
            if (wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== dv/dfadd_properties.sv
// port assertions for the double add block
`timescale 1ns/1ps
`default_nettype none
module dfadd_properties
    import dfadd_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire mem_req_s    mem_req,
    input wire mem_rsp_s    mem_rsp,
    input wire logic        overlap_inhibit,
    input wire logic        busy
);
    localparam int MAX_BUSY = 300;
    logic        ctrl_wr_ff;
    logic [14:0] y_ff;
    logic        word_ff;
    int          busy_cnt_ff;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_wr_ff  <= 1'b0;
            y_ff        <= '0;
            word_ff     <= 1'b0;
            busy_cnt_ff <= 0;
        end else begin
            ctrl_wr_ff  <= hsel && htrans[1] && hwrite && haddr == 32'h0;
            if (ctrl_wr_ff) y_ff <= hwdata[30:16];
            if (!mem_req.valid) word_ff <= 1'b0;
            else if (mem_rsp.ack) word_ff <= 1'b1;
            busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;
        end
    end
    sequence start_s;
        ctrl_wr_ff && hwdata[CTRL_START] && !busy;
    endsequence
    sequence first_word_s;
        mem_req.valid && mem_rsp.ack && !word_ff;
    endsequence
    busy_mirror_a: assert property (busy == overlap_inhibit)
        else $error("busy and overlap inhibit differ");
    fetch_busy_a: assert property (mem_req.valid |-> overlap_inhibit)
        else $error("fetch without overlap inhibit");
    idle_fetch_a: assert property (!busy |-> !mem_req.valid)
        else $error("fetch while idle");
    fetch_start_a: assert property (start_s |=> mem_req.valid &&
        mem_req.addr == y_ff) else $error("fetch of word y missing");
    addr_hold_a: assert property (mem_req.valid && !mem_rsp.ack |=>
        mem_req.valid && $stable(mem_req.addr)) else $error("request moved");
    next_word_a: assert property (first_word_s |=> mem_req.valid &&
        mem_req.addr == $past(mem_req.addr) + 15'h1) else $error("no y+1");
    last_word_a: assert property (word_ff && mem_rsp.ack |=>
        !mem_req.valid) else $error("fetch past second word");
    busy_bound_a: assert property (busy_cnt_ff < MAX_BUSY)
        else $error("operation too long");
endmodule
bind double_precision_float_add dfadd_properties u_dfadd_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .overlap_inhibit(overlap_inhibit), .busy(busy));
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the double add block
`timescale 1ns/1ps
`default_nettype none
module tb
    import dfadd_pkg::*;
;
    typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_s;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rnd;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, overlap_inhibit, busy, rd_pend = 1'b0;
    mem_req_s    mem_req;
    mem_rsp_s    mem_rsp;
    note_s       notes[$];
    int          err_count = 0, compares = 0;
    always #4 hclk = ~hclk;
    double_precision_float_add u_double_precision_float_add (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .overlap_inhibit(overlap_inhibit), .busy(busy));
    mem_model u_mem_model (.hclk(hclk), .hresetn(hresetn),
        .mem_req(mem_req), .mem_rsp(mem_rsp));
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(string n, logic [7:0] a, logic [31:0] e,
                      logic [31:0] m = 32'hFFFFFFFF);
        notes.push_back('{n, e & m, m});
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic put36(logic [7:0] a, logic [35:0] w);
        bus(a, 1'b1, w[31:0]);
        bus(a + 8'h4, 1'b1, {28'h0, w[35:32]});
    endtask
    task automatic get36(string n, logic [7:0] a, logic [35:0] w);
        rd(n, a, w[31:0]);
        rd(n, a + 8'h4, {28'h0, w[35:32]});
    endtask
    // load operands, start, wait for the end and check operand registers, status and control
    task automatic run(logic [35:0] ac, mq, y0, y1, logic [3:0] y, logic raw,
                       logic [35:0] mop);
        u_mem_model.words[y] = y0;
        u_mem_model.words[y + 4'h1] = y1;
        put36(HIGH_LO_OFF, ac);
        put36(LOW_LO_OFF, mq);
        bus(CTRL_OFF, 1'b1, {12'h0, y, 14'h0, raw, 1'b1});
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge hclk);
        check("busy", {31'h0, busy}, 32'h0);
        get36("memory operand", MOP_LO_OFF, mop);
        get36("backup operand", BOP_LO_OFF, y1);
        rd("status", STATUS_OFF, 32'h2, 32'hF);
        rd("control", CTRL_OFF, {12'h0, y, 14'h0, raw, 1'b0}, 32'h7FFF0002);
    endtask
    // read data phase ends at this edge, hrdata still holds its value
    always @(posedge hclk) begin
        if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
            check(notes[0].n, hrdata & notes[0].m, notes[0].e);
            void'(notes.pop_front());
        end
        rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        void'($urandom(68562));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd("status", STATUS_OFF, 32'h0);
        rd("unmapped", 8'h30, 32'h0);
        rnd = $urandom();
        put36(HIGH_LO_OFF, {4'h0, rnd});
        get36("result high", HIGH_LO_OFF, {4'h0, rnd});
        // equal characteristics, true add with fraction carry
        run(36'h404000000, 36'h328000000, 36'h404000000, 36'hFF8000000,
            4'h4, 1'b0, 36'h32C000000);
        get36("result high", HIGH_LO_OFF, 36'h40C000000);
        get36("result low", LOW_LO_OFF, 36'h330000000);
        // characteristic gap above the limit ends early
        run(36'h404000000, 36'h328000000, 36'hE0C000001, 36'h001234567,
            4'h8, 1'b1, 36'hD31234567);
        get36("result high", HIGH_LO_OFF, 36'hE0C000001);
        get36("result low", LOW_LO_OFF, 36'hD31234567);
        // unlike signs, complement add without carry, then normalize
        run(36'h404000000, 36'h0, 36'hC02000000, 36'h0, 4'h2, 1'b0,
            36'hB28000000);
        get36("result high", HIGH_LO_OFF, 36'h3FC000000);
        get36("result low", LOW_LO_OFF, 36'h320000000);
        @(posedge hclk);
        test_done();
    end
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
